// [core/ppfs_pkg.sv]
// Contract
// - serial unit B pins are plain port pins only when mode and clock select are 00H; the SI pin stays a port pin in every mode
// - oscillator pins become resonator or clock inputs only once selected in clock_pin_mode_reg
// - clock_pin_mode_reg reads 00H after reset, so all four pins are ports
// - a write to analog_pin_config_reg stalls the bus by an inserted wait cycle
package ppfs_pkg;

    // ----------------------------------------
    // register index map (byte address = 4 * index)
    // ----------------------------------------
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] IDX_SERIAL_B_MODE_REG = 5'h00;
    localparam logic [IDX_W-1:0] IDX_SERIAL_B_CLOCK_SELECT_REG = 5'h01;
    localparam logic [IDX_W-1:0] IDX_CLOCK_PIN_MODE_REG = 5'h02;
    localparam logic [IDX_W-1:0] IDX_ANALOG_PIN_CONFIG_REG = 5'h03;
    localparam logic [IDX_W-1:0] IDX_PORT_ZERO_DIRECTION_REG = 5'h04;
    localparam logic [IDX_W-1:0] IDX_SERIAL_PORT_DIRECTION_REG = 5'h05;
    localparam logic [IDX_W-1:0] IDX_ANALOG_PORT_DIRECTION_REG = 5'h06;
    localparam logic [IDX_W-1:0] IDX_PORT_THREE_DIRECTION_REG = 5'h07;
    localparam logic [IDX_W-1:0] IDX_PORT_SIX_DIRECTION_REG = 5'h0a;
    localparam logic [IDX_W-1:0] IDX_OSCILLATOR_PORT_DIRECTION_REG = 5'h0b;
    localparam logic [IDX_W-1:0] IDX_PORT_FOURTEEN_DIRECTION_REG = 5'h0c;
    localparam logic [IDX_W-1:0] IDX_SERIAL_PORT_LATCH_REG = 5'h0d;
    localparam logic [IDX_W-1:0] IDX_ANALOG_PORT_LATCH_REG = 5'h0e;
    localparam logic [IDX_W-1:0] IDX_OSCILLATOR_PORT_LATCH_REG = 5'h0f;
    localparam logic [IDX_W-1:0] IDX_SERIAL_PORT_PINS = 5'h10;
    localparam logic [IDX_W-1:0] IDX_ANALOG_PORT_PINS = 5'h11;
    localparam logic [IDX_W-1:0] IDX_OSCILLATOR_PORT_PINS = 5'h12;
    localparam int NUM_RW_REGS = 16;

    // ----------------------------------------
    // reset values and fixed-to-one masks
    // ----------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] FIX_NONE = 8'h00;
    localparam logic [7:0] FIX_PORT_ZERO = 8'h80;
    localparam logic [7:0] FIX_PORT_THREE_TO_SIX = 8'hf0;
    localparam logic [7:0] FIX_PORT_TWELVE = 8'he0;
    localparam logic [7:0] FIX_PORT_FOURTEEN = 8'hfc;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CPM_MAIN_OSC = 0;
    localparam int CPM_MAIN_EXT = 1;
    localparam int CPM_SUB_OSC = 2;
    localparam int CPM_SUB_EXT = 3;
    localparam int SER_PIN_SCK = 0;
    localparam int SER_PIN_SI = 1;
    localparam int SER_PIN_SO = 2;
    localparam int OSC_PIN_A = 1;
    localparam int OSC_PIN_B = 2;
    localparam int OSC_PIN_C = 3;
    localparam int OSC_PIN_D = 4;
    localparam int OSC_PORT_W = 5;
    localparam int BYTE_LANE0 = 0;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int APC_WAIT_CYCLES = 1;
    localparam int WAIT_CNT_W = 4;

    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_STALL = 3'h2,
        S_ACK = 3'h4
    } ppfs_bus_st_t;

    function automatic logic ppfs_is_dir(input logic [IDX_W-1:0] idx);
        ppfs_is_dir = (idx >= IDX_PORT_ZERO_DIRECTION_REG) &&
                      (idx <= IDX_PORT_FOURTEEN_DIRECTION_REG);
    endfunction

    function automatic logic [7:0] ppfs_fix_mask(input logic [IDX_W-1:0] idx);
        if (idx == IDX_PORT_ZERO_DIRECTION_REG) begin
            ppfs_fix_mask = FIX_PORT_ZERO;
        end else if (idx >= IDX_PORT_THREE_DIRECTION_REG && idx <= IDX_PORT_SIX_DIRECTION_REG) begin
            ppfs_fix_mask = FIX_PORT_THREE_TO_SIX;
        end else if (idx == IDX_OSCILLATOR_PORT_DIRECTION_REG) begin
            ppfs_fix_mask = FIX_PORT_TWELVE;
        end else if (idx == IDX_PORT_FOURTEEN_DIRECTION_REG) begin
            ppfs_fix_mask = FIX_PORT_FOURTEEN;
        end else begin
            ppfs_fix_mask = FIX_NONE;
        end
    endfunction

endpackage

// [core/ppfs_wait_gen.sv]
`timescale 1ns/1ps
module ppfs_wait_gen
    import ppfs_pkg::*;
#(
    parameter int WAIT_CYCLES = APC_WAIT_CYCLES
) (
    input wire logic clk_sys_i,   // system clock
    input wire logic reset_n_i,   // async reset, active low
    input wire logic start_i,     // pulse: begin a wait
    input wire logic stopped_i,   // peripheral clock stopped
    output logic done_o           // wait finished this cycle
);

    initial begin
        if (WAIT_CYCLES < 1 || WAIT_CYCLES >= (1 << WAIT_CNT_W)) begin
            $error("ppfs_wait_gen: WAIT_CYCLES out of range");
        end
    end

    logic [WAIT_CNT_W-1:0] cnt;
    localparam logic [WAIT_CNT_W-1:0] LAST = WAIT_CNT_W'(WAIT_CYCLES - 1);

    // the wait only advances on peripheral clock activity; with it stopped it never ends
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= '0;
        end else if (start_i) begin
            cnt <= '0;
        end else if (!stopped_i && cnt != LAST) begin
            cnt <= cnt + 1'b1;
        end
    end

    assign done_o = !start_i && !stopped_i && (cnt == LAST);

endmodule

// [core/ppfs_pin_cell.sv]
`timescale 1ns/1ps
module ppfs_pin_cell #(
    parameter int W = 8
) (
    input wire logic clk_sys_i,          // system clock
    input wire logic reset_n_i,          // async reset, active low
    input wire logic [W-1:0] dir_i,      // 1 = input, 0 = output
    input wire logic [W-1:0] latch_i,    // port output latch
    input wire logic [W-1:0] alt_en_i,   // pin handed to a peripheral
    input wire logic [W-1:0] alt_out_i,  // peripheral output level
    input wire logic [W-1:0] alt_drv_i,  // peripheral drives the pin
    input wire logic [W-1:0] iso_i,      // digital input buffer cut off
    input wire logic [W-1:0] pin_i,      // pin level
    output logic [W-1:0] pin_o,          // pin output level
    output logic [W-1:0] pin_oe_n_o,     // low while driving
    output logic [W-1:0] din_o           // sampled digital input
);

    initial begin
        if (W < 1 || W > 8) begin
            $error("ppfs_pin_cell: W must be 1..8");
        end
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_pin
            always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    pin_o[g] <= 1'b0;
                    pin_oe_n_o[g] <= 1'b1;
                    din_o[g] <= 1'b0;
                end else begin
                    if (alt_en_i[g]) begin
                        pin_o[g] <= alt_out_i[g];
                        pin_oe_n_o[g] <= !alt_drv_i[g];
                    end else begin
                        pin_o[g] <= latch_i[g];
                        pin_oe_n_o[g] <= dir_i[g];
                    end
                    // an isolated pin reads low so analog levels do not toggle logic
                    din_o[g] <= pin_i[g] && !iso_i[g];
                end
            end
        end
    endgenerate

endmodule

// [core/ppfs_top.sv]
`timescale 1ns/1ps
module ppfs_top
    import ppfs_pkg::*;
(
    input wire logic clk_sys_i,                    // system clock, 40 MHz
    input wire logic reset_n_i,                    // async reset, active low
    input wire logic [7:0] avs_address_i,          // byte address
    input wire logic avs_read_i,                   // read request
    input wire logic avs_write_i,                  // write request
    input wire logic [31:0] avs_writedata_i,       // write data
    input wire logic [3:0] avs_byteenable_i,       // byte enables
    output logic [31:0] avs_readdata_o,            // read data
    output logic avs_waitrequest_o,                // stall
    input wire logic periph_clk_stopped_i,         // peripheral clock stopped
    input wire logic serial_sck_out_i,             // serial unit B clock out
    input wire logic serial_sck_drive_i,           // serial unit B drives clock
    input wire logic serial_so_i,                  // serial unit B data out
    output logic serial_si_o,                      // serial unit B data in
    output logic serial_b_active_o,                // serial unit B owns its pins
    input wire logic [7:0] serial_port_pin_i,      // port 1 pin levels
    output logic [7:0] serial_port_pin_o,          // port 1 drive levels
    output logic [7:0] serial_port_pin_oe_n_o,     // port 1 enables, low drives
    input wire logic [7:0] analog_port_pin_i,      // port 2 pin levels
    output logic [7:0] analog_port_pin_o,          // port 2 drive levels
    output logic [7:0] analog_port_pin_oe_n_o,     // port 2 enables, low drives
    output logic [7:0] analog_channel_en_o,        // analog channel connected
    input wire logic [4:0] osc_port_pin_i,         // port 12 pin levels
    output logic [4:0] osc_port_pin_o,             // port 12 drive levels
    output logic [4:0] osc_port_pin_oe_n_o,        // port 12 enables, low drives
    output logic main_resonator_en_o,              // main oscillator amplifier on
    output logic sub_resonator_en_o,               // sub oscillator amplifier on
    output logic main_external_clock_in_o,         // main external clock level
    output logic sub_external_clock_in_o           // sub external clock level
);

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [7:0] reg_q [NUM_RW_REGS];
    logic [7:0] ser_din;
    logic [7:0] ana_din;
    logic [4:0] osc_din;
    logic [IDX_W-1:0] idx;
    logic addr_ok;
    logic commit;
    logic cpm_written;

    assign idx = avs_address_i[IDX_W+1:2];
    assign addr_ok = (avs_address_i[1:0] == 2'h0) && (avs_address_i[7] == 1'b0);

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    ppfs_bus_st_t state;
    ppfs_bus_st_t next_state;
    logic req;
    logic apc_wr;
    logic wait_done;

    assign req = avs_read_i || avs_write_i;
    assign apc_wr = avs_write_i && addr_ok && (idx == IDX_ANALOG_PIN_CONFIG_REG);

    ppfs_wait_gen #(
        .WAIT_CYCLES(APC_WAIT_CYCLES)
    ) u_wait (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .start_i(state == S_IDLE && apc_wr),
        .stopped_i(periph_clk_stopped_i),
        .done_o(wait_done)
    );

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (apc_wr) begin
                    next_state = S_STALL;
                end else if (req) begin
                    next_state = S_ACK;
                end
            end
            S_STALL: begin
                if (wait_done) begin
                    next_state = S_ACK;
                end
            end
            S_ACK: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // every access except a config write costs one wait so read data come from a flop
    assign avs_waitrequest_o = req && (state != S_ACK);
    assign commit = (state == S_ACK) && avs_write_i && addr_ok && avs_byteenable_i[BYTE_LANE0];

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_readdata_o <= '0;
        end else if (state == S_IDLE && avs_read_i) begin
            avs_readdata_o <= '0;
            if (addr_ok && idx < IDX_W'(NUM_RW_REGS)) begin
                avs_readdata_o[7:0] <= reg_q[idx[3:0]];
            end else if (addr_ok && idx == IDX_SERIAL_PORT_PINS) begin
                avs_readdata_o[7:0] <= ser_din;
            end else if (addr_ok && idx == IDX_ANALOG_PORT_PINS) begin
                avs_readdata_o[7:0] <= ana_din;
            end else if (addr_ok && idx == IDX_OSCILLATOR_PORT_PINS) begin
                avs_readdata_o[OSC_PORT_W-1:0] <= osc_din;
            end
        end
    end

    genvar r;
    generate
        for (r = 0; r < NUM_RW_REGS; r++) begin : g_reg
            localparam logic [IDX_W-1:0] RI = IDX_W'(r);
            // unused direction bits are held at 1 whatever software writes
            always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    reg_q[r] <= ppfs_is_dir(RI) ? RST_DIR : RST_ZERO;
                end else if (commit && idx == RI) begin
                    reg_q[r] <= avs_writedata_i[7:0] | ppfs_fix_mask(RI);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpm_written <= 1'b0;
        end else if (commit && idx == IDX_CLOCK_PIN_MODE_REG) begin
            cpm_written <= 1'b1;
        end
    end

    // ----------------------------------------
    // pin function selection
    // ----------------------------------------
    logic [7:0] cpm;
    logic [7:0] ser_alt_en;
    logic [7:0] ser_alt_out;
    logic [7:0] ser_alt_drv;
    logic [4:0] osc_alt;
    logic main_sel;
    logic sub_sel;

    assign cpm = reg_q[IDX_CLOCK_PIN_MODE_REG[3:0]];
    assign main_sel = cpm[CPM_MAIN_OSC] || cpm[CPM_MAIN_EXT];
    assign sub_sel = cpm[CPM_SUB_OSC] || cpm[CPM_SUB_EXT];

    always_comb begin
        ser_alt_en = '0;
        ser_alt_out = '0;
        ser_alt_drv = '0;
        ser_alt_en[SER_PIN_SCK] = serial_b_active_o;
        ser_alt_out[SER_PIN_SCK] = serial_sck_out_i;
        ser_alt_drv[SER_PIN_SCK] = serial_sck_drive_i;
        ser_alt_en[SER_PIN_SO] = serial_b_active_o;
        ser_alt_out[SER_PIN_SO] = serial_so_i;
        ser_alt_drv[SER_PIN_SO] = 1'b1;
        osc_alt = '0;
        osc_alt[OSC_PIN_A] = main_sel;
        osc_alt[OSC_PIN_B] = main_sel;
        osc_alt[OSC_PIN_C] = sub_sel;
        osc_alt[OSC_PIN_D] = sub_sel;
    end

    ppfs_pin_cell #(.W(8)) u_ser (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .dir_i(reg_q[IDX_SERIAL_PORT_DIRECTION_REG[3:0]]),
        .latch_i(reg_q[IDX_SERIAL_PORT_LATCH_REG[3:0]]),
        .alt_en_i(ser_alt_en),
        .alt_out_i(ser_alt_out),
        .alt_drv_i(ser_alt_drv),
        .iso_i(8'h00),
        .pin_i(serial_port_pin_i),
        .pin_o(serial_port_pin_o),
        .pin_oe_n_o(serial_port_pin_oe_n_o),
        .din_o(ser_din)
    );

    // pins selected as analog never drive, whatever the direction register holds
    ppfs_pin_cell #(.W(8)) u_ana (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .dir_i(reg_q[IDX_ANALOG_PORT_DIRECTION_REG[3:0]]),
        .latch_i(reg_q[IDX_ANALOG_PORT_LATCH_REG[3:0]]),
        .alt_en_i(reg_q[IDX_ANALOG_PIN_CONFIG_REG[3:0]]),
        .alt_out_i(8'h00),
        .alt_drv_i(8'h00),
        .iso_i(reg_q[IDX_ANALOG_PIN_CONFIG_REG[3:0]]),
        .pin_i(analog_port_pin_i),
        .pin_o(analog_port_pin_o),
        .pin_oe_n_o(analog_port_pin_oe_n_o),
        .din_o(ana_din)
    );

    // oscillator pins ignore direction and latch once handed over
    ppfs_pin_cell #(.W(OSC_PORT_W)) u_osc (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .dir_i(reg_q[IDX_OSCILLATOR_PORT_DIRECTION_REG[3:0]][OSC_PORT_W-1:0]),
        .latch_i(reg_q[IDX_OSCILLATOR_PORT_LATCH_REG[3:0]][OSC_PORT_W-1:0]),
        .alt_en_i(osc_alt),
        .alt_out_i(5'h00),
        .alt_drv_i(5'h00),
        .iso_i(osc_alt),
        .pin_i(osc_port_pin_i),
        .pin_o(osc_port_pin_o),
        .pin_oe_n_o(osc_port_pin_oe_n_o),
        .din_o(osc_din)
    );

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_b_active_o <= 1'b0;
            serial_si_o <= 1'b0;
            analog_channel_en_o <= '0;
            main_resonator_en_o <= 1'b0;
            sub_resonator_en_o <= 1'b0;
            main_external_clock_in_o <= 1'b0;
            sub_external_clock_in_o <= 1'b0;
        end else begin
            serial_b_active_o <= (reg_q[IDX_SERIAL_B_MODE_REG[3:0]] != RST_ZERO) ||
                (reg_q[IDX_SERIAL_B_CLOCK_SELECT_REG[3:0]] != RST_ZERO);
            serial_si_o <= serial_port_pin_i[SER_PIN_SI];
            analog_channel_en_o <= reg_q[IDX_ANALOG_PIN_CONFIG_REG[3:0]];
            main_resonator_en_o <= cpm[CPM_MAIN_OSC] && !cpm[CPM_MAIN_EXT];
            sub_resonator_en_o <= cpm[CPM_SUB_OSC] && !cpm[CPM_SUB_EXT];
            main_external_clock_in_o <= cpm[CPM_MAIN_EXT] && osc_port_pin_i[OSC_PIN_B];
            sub_external_clock_in_o <= cpm[CPM_SUB_EXT] && osc_port_pin_i[OSC_PIN_D];
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_serial_gp;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reg_q[IDX_SERIAL_B_MODE_REG[3:0]] == RST_ZERO &&
         reg_q[IDX_SERIAL_B_CLOCK_SELECT_REG[3:0]] == RST_ZERO) [*2] |=>
        serial_port_pin_oe_n_o[SER_PIN_SO] ==
        $past(reg_q[IDX_SERIAL_PORT_DIRECTION_REG[3:0]][SER_PIN_SO]);
    endproperty
    a_serial_gp: assert property (p_serial_gp) else $error("serial pin not a port");

    property p_osc_handover;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        main_sel |=> osc_port_pin_oe_n_o[OSC_PIN_A] && osc_port_pin_oe_n_o[OSC_PIN_B] &&
        !osc_din[OSC_PIN_A];
    endproperty
    a_osc_handover: assert property (p_osc_handover) else $error("osc pin still a port");

    property p_cpm_reset;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !cpm_written |-> cpm == RST_ZERO && !main_resonator_en_o && !sub_resonator_en_o;
    endproperty
    a_cpm_reset: assert property (p_cpm_reset) else $error("clock pin mode not 00H");

    property p_apc_wait;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (state == S_IDLE && apc_wr) ##1 !periph_clk_stopped_i |->
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endproperty
    a_apc_wait: assert property (p_apc_wait) else $error("no wait on config write");

    property p_stall_hold;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (state == S_STALL && periph_clk_stopped_i) |=> state == S_STALL && avs_waitrequest_o;
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("wait ended, clock stopped");

    property p_fixed_ones;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        commit && idx == IDX_PORT_FOURTEEN_DIRECTION_REG |=>
        reg_q[IDX_PORT_FOURTEEN_DIRECTION_REG[3:0]][7:2] == FIX_PORT_FOURTEEN[7:2];
    endproperty
    a_fixed_ones: assert property (p_fixed_ones) else $error("fixed bit cleared");

    property p_dir_out;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!reg_q[IDX_ANALOG_PIN_CONFIG_REG[3:0]][0] &&
         !reg_q[IDX_ANALOG_PORT_DIRECTION_REG[3:0]][0]) |=>
        !analog_port_pin_oe_n_o[0] &&
        analog_port_pin_o[0] == $past(reg_q[IDX_ANALOG_PORT_LATCH_REG[3:0]][0]);
    endproperty
    a_dir_out: assert property (p_dir_out) else $error("output not from latch");

endmodule

// [verif/ppfs_pin_model.sv]
`timescale 1ns/1ps
// --------------------------------
// package pins of one port
// --------------------------------
module ppfs_pin_model #(
    parameter int W = 8
) (
    input wire logic clk_sys_i,         // system clock
    input wire logic [W-1:0] pin_o_i,   // block drive level
    input wire logic [W-1:0] oe_n_i,    // low while block drives
    output logic [W-1:0] pin_i_o        // level seen on the pins
);
    logic [W-1:0] pat = '0;
    // released pins wander every cycle so no stale level passes for data
    always_ff @(posedge clk_sys_i) begin
        pat <= ~pat;
    end
    assign pin_i_o = (~oe_n_i & pin_o_i) | (oe_n_i & pat);
endmodule

// [verif/test_port_pin_function_select.sv]
`timescale 1ns/1ps
module test_port_pin_function_select import ppfs_pkg::*;;
    logic clk = 1'b0, reset_n = 1'b0, rd = 1'b0, wr = 1'b0, so = 1'b1;
    logic stp = 1'b0, sck = 1'b0, sckd = 1'b0;
    logic [3:0] be = 4'h1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic wreq, si, act, mres, sres, mext, sext;
    logic [7:0] sp_i, sp_o, sp_oe, ap_i, ap_o, ap_oe, ach;
    logic [4:0] op_i, op_o, op_oe;
    logic [7:0] q;
    int n, fail_count = 0, cmp_count = 0;
    ppfs_top i_dut (.clk_sys_i(clk), .reset_n_i(reset_n), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .periph_clk_stopped_i(stp), .serial_sck_out_i(sck), .serial_sck_drive_i(sckd),
        .serial_so_i(so), .serial_si_o(si), .serial_b_active_o(act),
        .serial_port_pin_i(sp_i), .serial_port_pin_o(sp_o), .serial_port_pin_oe_n_o(sp_oe),
        .analog_port_pin_i(ap_i), .analog_port_pin_o(ap_o), .analog_port_pin_oe_n_o(ap_oe),
        .analog_channel_en_o(ach), .osc_port_pin_i(op_i), .osc_port_pin_o(op_o),
        .osc_port_pin_oe_n_o(op_oe), .main_resonator_en_o(mres), .sub_resonator_en_o(sres),
        .main_external_clock_in_o(mext), .sub_external_clock_in_o(sext));
    ppfs_pin_model #(.W(8)) i_sp (.clk_sys_i(clk), .pin_o_i(sp_o), .oe_n_i(sp_oe), .pin_i_o(sp_i));
    ppfs_pin_model #(.W(8)) i_ap (.clk_sys_i(clk), .pin_o_i(ap_o), .oe_n_i(ap_oe), .pin_i_o(ap_i));
    ppfs_pin_model #(.W(5)) i_op (.clk_sys_i(clk), .pin_o_i(op_o), .oe_n_i(op_oe), .pin_i_o(op_i));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] d);
        @(posedge clk);
        addr <= {1'b0, idx, 2'b00};
        wr <= w;
        rd <= ~w;
        wdata <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        bus(1'b0, IDX_CLOCK_PIN_MODE_REG, 8'h00); chk("clock_pin_mode", 8'h00, q);
        bus(1'b0, IDX_ANALOG_PORT_DIRECTION_REG, 8'h00); chk("dir reset", 8'hff, q);
        bus(1'b1, 5'h1f, 8'hff);
        bus(1'b0, 5'h1f, 8'h00); chk("unmapped", 8'h00, q);
    endtask
    task automatic t_fixed();
        bus(1'b1, IDX_PORT_ZERO_DIRECTION_REG, 8'h00);
        bus(1'b0, IDX_PORT_ZERO_DIRECTION_REG, 8'h00); chk("port0 dir", 8'h80, q);
        bus(1'b1, IDX_PORT_FOURTEEN_DIRECTION_REG, 8'h00);
        bus(1'b0, IDX_PORT_FOURTEEN_DIRECTION_REG, 8'h00); chk("port14 dir", 8'hfc, q);
        be <= 4'h0;
        bus(1'b1, IDX_PORT_ZERO_DIRECTION_REG, 8'hff);
        be <= 4'h1;
        bus(1'b0, IDX_PORT_ZERO_DIRECTION_REG, 8'h00); chk("lane off", 8'h80, q);
        bus(1'b1, IDX_PORT_ZERO_DIRECTION_REG, 8'hff);
        bus(1'b1, IDX_PORT_FOURTEEN_DIRECTION_REG, 8'hff);
    endtask
    task automatic t_dir();
        bus(1'b1, IDX_ANALOG_PORT_LATCH_REG, 8'ha5);
        bus(1'b1, IDX_ANALOG_PORT_DIRECTION_REG, 8'h00);
        settle();
        chk("p2 drive", 8'ha5, ap_o);
        chk("p2 oe_n", 8'h00, ap_oe);
        bus(1'b0, IDX_ANALOG_PORT_PINS, 8'h00); chk("p2 pins", 8'ha5, q);
        bus(1'b1, IDX_ANALOG_PORT_DIRECTION_REG, 8'hff);
        settle();
        chk("p2 oe_n in", 8'hff, ap_oe);
    endtask
    task automatic t_analog();
        bus(1'b1, IDX_ANALOG_PIN_CONFIG_REG, 8'h0f); chk("config wait", 8'h03, n[7:0]);
        stp <= 1'b1;
        bus(1'b1, IDX_ANALOG_PORT_LATCH_REG, 8'h00); chk("plain wait", 8'h02, n[7:0]);
        settle();
        chk("channels", 8'h0f, ach);
        // a config write with the peripheral clock stopped must hang until it runs again
        @(posedge clk);
        addr <= {1'b0, IDX_ANALOG_PIN_CONFIG_REG, 2'b00};
        wr <= 1'b1;
        wdata <= 32'h0000_0003;
        repeat (6) @(posedge clk);
        chk("stalled", 8'h01, {7'h00, wreq});
        chk("no commit", 8'h0f, ach);
        stp <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0);
        wr <= 1'b0;
        chk("resumed", 8'h02, n[7:0]);
        settle();
        chk("channels late", 8'h03, ach);
    endtask
    task automatic t_serial();
        chk("serial idle", 8'h00, {7'h00, act});
        @(posedge clk);
        sck <= 1'b1;
        sckd <= 1'b1;
        bus(1'b1, IDX_SERIAL_B_MODE_REG, 8'h01);
        settle();
        chk("serial act", 8'h01, {7'h00, act});
        chk("so sck pins", 8'h0f, {4'h0, sp_o[2], ~sp_oe[2], sp_o[0], ~sp_oe[0]});
        bus(1'b1, IDX_SERIAL_B_MODE_REG, 8'h00);
        sckd <= 1'b0;
        bus(1'b1, IDX_SERIAL_B_CLOCK_SELECT_REG, 8'h40);
        settle();
        chk("csel act", 8'h01, {7'h00, act});
        chk("sck input", 8'h01, {7'h00, sp_oe[0]});
        bus(1'b1, IDX_SERIAL_B_CLOCK_SELECT_REG, 8'h00);
        settle();
        chk("serial off", 8'h00, {7'h00, act});
        chk("sck released", 8'h03, {6'h00, sp_oe[2], sp_oe[0]});
        bus(1'b1, IDX_SERIAL_PORT_LATCH_REG, 8'h02);
        bus(1'b1, IDX_SERIAL_PORT_DIRECTION_REG, 8'hfd);
        settle();
        chk("si", 8'h01, {7'h00, si});
    endtask
    task automatic t_osc();
        bus(1'b1, IDX_OSCILLATOR_PORT_LATCH_REG, 8'h1f);
        bus(1'b1, IDX_OSCILLATOR_PORT_DIRECTION_REG, 8'he0);
        settle();
        chk("osc port oe_n", 8'h00, {3'h0, op_oe});
        chk("osc port drive", 8'h1f, {3'h0, op_o});
        bus(1'b1, IDX_CLOCK_PIN_MODE_REG, 8'h01);
        settle();
        chk("main res", 8'h07, {5'h00, mres, op_oe[2:1]});
        bus(1'b1, IDX_CLOCK_PIN_MODE_REG, 8'h04);
        settle();
        chk("sub res", 8'h1c, {3'h0, sres, op_oe[4:3], op_oe[2:1]});
        bus(1'b1, IDX_CLOCK_PIN_MODE_REG, 8'h0a);
        settle();
        chk("ext clk", 8'h0f, {2'h0, mres, sres, op_oe[4:1]});
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_fixed();
        t_dir();
        t_analog();
        t_serial();
        t_osc();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule
